/* verilog/lut_consts.vh */
// constants for the lookup table rom: data formats, source word layout,
// default build options; included by the rom module only.
`ifndef LUT_CONSTS_VH
`define LUT_CONSTS_VH

// data format codes
`define LUT_FMT_SINT     2'h0
`define LUT_FMT_SFRAC    2'h1
`define LUT_FMT_UINT     2'h2
`define LUT_FMT_BIT      2'h3

// each source entry is a signed raw fixed-point value this wide
`define LUT_SRC_W        32

// default build choices and address width limits
`define LUT_DEF_ADDR_W   4
`define LUT_DEF_INT_W    8
`define LUT_DEF_FRAC_W   0
`define LUT_DEF_LEN      4
`define LUT_MIN_ADDR_W   2
`define LUT_MAX_ADDR_W   16

// register reset value
`define LUT_RST_WORD     1'b0

`endif

/* verilog/lut_rom.v */
// lookup table rom: build-time constant table indexed by an unsigned
// address, optional address/output registers and clock enable.
// assumes a synchronous datapath on core_clk_i drives the address.
`timescale 1ns/10ps
`default_nettype none
`include "lut_consts.vh"

module lut_rom #(
	parameter                 ADDR_W        = `LUT_DEF_ADDR_W,
	parameter [1:0]           DATA_FMT      = `LUT_FMT_SINT,
	parameter                 INT_W         = `LUT_DEF_INT_W,
	parameter                 FRAC_W        = `LUT_DEF_FRAC_W,
	parameter                 TABLE_LEN     = `LUT_DEF_LEN,
	parameter [TABLE_LEN*`LUT_SRC_W-1:0] TABLE_INIT = {TABLE_LEN{32'h0}},
	parameter                 USE_ENA       = 0,
	parameter                 REG_DATA      = 0,
	parameter                 REG_ADDR      = 0,
	parameter                 USE_PARAM_ROM = 0,
	// derived output width, not meant to be overridden
	parameter                 OUT_W         = (DATA_FMT == `LUT_FMT_BIT) ?
		1 : ((DATA_FMT == `LUT_FMT_SFRAC) ? INT_W + FRAC_W : INT_W)
) (
	// clock and reset
	input  wire               core_clk_i,
	input  wire               rst_i,
	// lookup request
	input  wire [ADDR_W-1:0]  addr_i,
	input  wire               ena_i,
	// lookup answer and build status
	output wire [OUT_W-1:0]   data_o,
	output wire               table_inexact_o
);

	// number of table words
	localparam DEPTH     = 1 << ADDR_W;
	// address registered when asked, always for the param rom form
	localparam ADDR_REGD = (REG_ADDR != 0) || (USE_PARAM_ROM != 0);

	// stage advance: enable port only counts when built in
	wire stage_adv;
	assign stage_adv = (USE_ENA != 0) ? ena_i : 1'b1;

	// unpacked table, words past the supplied array are zero
	wire [OUT_W-1:0] lut_word [0:DEPTH-1];
	// per-entry inexact flags chained into one
	wire [DEPTH:0]   inexact_chain;
	assign inexact_chain[0] = 1'b0;

	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_word
			if (gi < TABLE_LEN) begin : g_src
				wire signed [`LUT_SRC_W-1:0] src_val;
				wire [OUT_W-1:0]             trunc;
				wire                         fits;
				assign src_val = TABLE_INIT[gi*`LUT_SRC_W +: `LUT_SRC_W];
				assign trunc   = src_val[OUT_W-1:0];
				// signed formats must sign-extend back, others zero-extend
				assign fits = (DATA_FMT == `LUT_FMT_SINT ||
					DATA_FMT == `LUT_FMT_SFRAC) ?
					($signed({{(`LUT_SRC_W){trunc[OUT_W-1]}}, trunc})
						== src_val) :
					({{(`LUT_SRC_W){1'b0}}, trunc} ==
						{{(OUT_W){1'b0}}, src_val});
				assign lut_word[gi] = trunc;
				assign inexact_chain[gi+1] = inexact_chain[gi] | ~fits;
			end else begin : g_zero
				assign lut_word[gi] = {OUT_W{1'b0}};
				assign inexact_chain[gi+1] = inexact_chain[gi];
			end
		end
	endgenerate

	// build-time flag: some entry does not fit the chosen format
	assign table_inexact_o = inexact_chain[DEPTH];

	// param rom form: table word chosen by case conditions
	function [OUT_W-1:0] param_rom_fn;
		input [ADDR_W-1:0] a;
		input [OUT_W-1:0]  w;
		begin
			case ({{(`LUT_SRC_W-ADDR_W){1'b0}}, a} < TABLE_LEN)
				1'b1:    param_rom_fn = w;
				default: param_rom_fn = {OUT_W{1'b0}};
			endcase
		end
	endfunction

	// address stage
	reg  [ADDR_W-1:0] addr_q;
	wire [ADDR_W-1:0] addr_use;
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			addr_q <= {ADDR_W{`LUT_RST_WORD}};
		end else if (stage_adv) begin
			addr_q <= addr_i;
		end
	end
	assign addr_use = ADDR_REGD ? addr_q : addr_i;

	// lookup
	wire [OUT_W-1:0] look_word;
	assign look_word = (USE_PARAM_ROM != 0) ?
		param_rom_fn(addr_use, lut_word[addr_use]) : lut_word[addr_use];

	// output stage
	reg [OUT_W-1:0] data_q;
	always @(posedge core_clk_i) begin
		if (rst_i) begin
			data_q <= {OUT_W{`LUT_RST_WORD}};
		end else if (stage_adv) begin
			data_q <= look_word;
		end
	end
	assign data_o = (REG_DATA != 0) ? data_q : look_word;

endmodule
`default_nettype wire

/* test/lut_drv.sv */
// far-side model: synchronous datapath driving address and enable
// assumes the bench sets a_i/e_i after a rising edge
`timescale 1ns/10ps
`default_nettype none
module lut_drv (
	input  wire logic       core_clk_i,
	input  wire logic [3:0] a_i,
	input  wire logic       e_i,
	output var  logic [3:0] addr_o,
	output var  logic       ena_o
);
	// launch on the falling edge, held a full cycle
	initial addr_o = 4'h0;
	initial ena_o = 1'b0;
	always @(negedge core_clk_i) begin
		addr_o <= a_i;
		ena_o  <= e_i;
	end
endmodule
`default_nettype wire

/* test/lut_chk_checker.sv */
// port checker for the lookup table rom
// assumes address and data registers and the enable are built in
`timescale 1ns/10ps
`default_nettype none
module lut_chk #(parameter ADDR_W = 4, OUT_W = 8, TABLE_LEN = 4) (
	input wire logic              core_clk_i,
	input wire logic              rst_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic              ena_i,
	input wire logic [OUT_W-1:0]  data_o,
	input wire logic              table_inexact_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	hold_when_idle_a: assert property (!ena_i |=> $stable(data_o))
		else $error("word moved while enable low");
	zero_beyond_a: assert property (ena_i && addr_i >= TABLE_LEN ##1 ena_i
		|=> data_o == 0) else $error("missing word not zero");
	same_addr_a: assert property (ena_i ##1 ena_i && $stable(addr_i)
		|=> ##1 $stable(data_o)) else $error("repeat read differs");
	build_flag_a: assert property ($stable(table_inexact_o))
		else $error("build flag changed");
	reg_clear_a: assert property (disable iff (1'b0) rst_i |=> data_o == 0)
		else $error("output register not cleared");
	reset_hold_a: assert property (disable iff (1'b0)
		rst_i ##1 rst_i |-> data_o == 0)
		else $error("output moved during reset");
	cover property (ena_i && addr_i >= TABLE_LEN);
	cover property (!ena_i ##1 !ena_i);
	cover property (ena_i ##1 ena_i);
endmodule
bind lut_rom lut_chk #(.ADDR_W(ADDR_W), .OUT_W(OUT_W),
	.TABLE_LEN(TABLE_LEN)) u_lut_chk (.core_clk_i(core_clk_i),
	.rst_i(rst_i), .addr_i(addr_i), .ena_i(ena_i), .data_o(data_o),
	.table_inexact_o(table_inexact_o));
`default_nettype wire

/* test/lut_rom_tb_top.sv */
// testbench for the lookup table rom, signed 8-bit words, 16 places
// assumes the driver model launches inputs on the falling edge
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, w) begin samples_checked++; if ((g) !== (w)) begin \
	n_mismatch++; $display("[FAIL] %0t got %h want %h", $time, g, w); end end
module lut_rom_tb_top;
	localparam [127:0] TBL = {32'hffffff80, 32'h7f, 32'hfffffff0, 32'h5};
	logic       core_clk_i = 0, rst_i = 1, e = 0;
	logic [3:0] a = 4'h0;
	wire  [3:0] addr;
	wire        ena, inex;
	wire  [7:0] data_o;
	int         n_mismatch = 0, samples_checked = 0;
	lut_rom #(.TABLE_LEN(4), .TABLE_INIT(TBL), .USE_ENA(1), .REG_DATA(1),
		.REG_ADDR(1)) u_lut_rom (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.addr_i(addr), .ena_i(ena), .data_o(data_o), .table_inexact_o(inex));
	lut_drv u_lut_drv (.core_clk_i(core_clk_i), .a_i(a), .e_i(e),
		.addr_o(addr), .ena_o(ena));
	function automatic logic [7:0] want(int k);
		return (k < 4) ? TBL[k*32 +: 8] : 8'h00;
	endfunction
	// sweep all places back to back, two cycles of latency
	task t_read;
		for (int i = 0; i < 18; i++) begin
			@(posedge core_clk_i) a = i[3:0];
			e = 1'b1;
			@(negedge core_clk_i) if (i > 1) `CHK(data_o, want(i - 2))
		end
		`CHK(inex, 1'b0)
		$display("t_read done");
	endtask
	// enable low freezes both stages
	task t_hold;
		@(posedge core_clk_i) a = 4'h3;
		e = 1'b0;
		repeat (4) @(negedge core_clk_i);
		`CHK(data_o, want(0))
		@(posedge core_clk_i) e = 1'b1;
		repeat (2) @(negedge core_clk_i);
		`CHK(data_o, want(1))
		$display("t_hold done");
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial forever #20 core_clk_i = ~core_clk_i;
	initial begin
		repeat (20) @(negedge core_clk_i);
		rst_i = 1'b0;
		t_read;
		t_hold;
		summarize;
	end
	initial begin
		#10000 n_mismatch++;
		summarize;
	end
endmodule
`default_nettype wire
